// ===== rtl/vmon_pkg.sv
// package: constants and carriers for the voltage monitor control block
package vmon_pkg;
    // filter sampling clock select codes
    localparam logic [1:0] FCLK_DIV1 = 2'h0;
    localparam logic [1:0] FCLK_DIV2 = 2'h1;
    localparam logic [1:0] FCLK_DIV4 = 2'h2;
    localparam logic [1:0] FCLK_DIV8 = 2'h3;
    // filter settle before qualified detections count, in sample clocks
    localparam int unsigned FILT_SETTLE = 4;
    localparam logic [2:0] FILT_SETTLE_C = 3'h4;
    localparam logic [2:0] SMP_DIV_W0 = 3'h0;
    // mode and timing select encoding
    localparam logic MODE_IRQ = 1'b0;
    localparam logic MODE_RST = 1'b1;
    localparam logic TIMING_FALL = 1'b1;

    // control bits of one monitor, written as one word
    typedef struct packed {
        logic req_timing;
        logic mode_sel;
        logic filter_off;
        logic [1:0] filter_clk_sel;
    } mon_cfg_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SETTLE = 2'b01,
        ST_ARMED = 2'b11
    } mon_state_t;
endpackage

// ===== rtl/vmon_ctrl.sv
// voltage monitor 1 and 2 control: filter, flags, interrupt and reset requests
`timescale 1ns/1ps
module vmon_ctrl
    import vmon_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic LSO_CLK,
    input wire logic LSO_STOP,
    input wire logic DET1_CIRCUIT_EN,
    input wire logic DET2_CIRCUIT_EN,
    input wire logic CMP1_BELOW,
    input wire logic CMP2_BELOW,
    input wire vmon_pkg::mon_cfg_t MON1_CFG_WDATA,
    input wire logic MON1_CFG_WE,
    input wire logic MON1_EN,
    input wire logic MON1_FLAG_CLR,
    input wire vmon_pkg::mon_cfg_t MON2_CFG_WDATA,
    input wire logic MON2_CFG_WE,
    input wire logic MON2_EN,
    input wire logic MON2_FLAG_CLR,
    output logic [4:0] MON1_CFG,
    output logic [4:0] MON2_CFG,
    output logic MON1_PASS_FLAG,
    output logic MON2_PASS_FLAG,
    output logic MON1_ARMED,
    output logic MON2_ARMED,
    output logic MON2_IRQ,
    output logic CHIP_RST_REQ
);
    import vmon_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [4:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
    // order: lso clock, cmp1, cmp2, det1, det2
    always_comb begin
        sync1_nxt = {LSO_CLK, CMP1_BELOW, CMP2_BELOW, DET1_CIRCUIT_EN, DET2_CIRCUIT_EN};
        sync2_nxt = sync1_r;
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end
    logic lso_s, cmp1_s, cmp2_s, det1_s, det2_s;
    assign lso_s = sync2_r[4];
    assign cmp1_s = sync2_r[3];
    assign cmp2_s = sync2_r[2];
    assign det1_s = sync2_r[1];
    assign det2_s = sync2_r[0];

    // ----------------------------------------------------------------
    // sampling tick: lso rising edge divided per select
    // ----------------------------------------------------------------
    logic lso_d_r, lso_d_nxt;
    logic [2:0] div_r, div_nxt;
    logic lso_rise;
    assign lso_rise = lso_s & ~lso_d_r & ~LSO_STOP; // stopped oscillator gives no ticks
    always_comb begin
        lso_d_nxt = lso_s;
        div_nxt = lso_rise ? div_r + 3'h1 : div_r;
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            lso_d_r <= 1'b0;
            div_r <= SMP_DIV_W0;
        end else begin
            lso_d_r <= lso_d_nxt;
            div_r <= div_nxt;
        end
    end

    // tick for a given select; shared by both monitors
    function automatic logic smp_tick(input logic [1:0] sel, input logic rise, input logic [2:0] cnt);
        case (sel)
            FCLK_DIV1: smp_tick = rise;
            FCLK_DIV2: smp_tick = rise & (cnt[0] == 1'b0);
            FCLK_DIV4: smp_tick = rise & (cnt[1:0] == 2'h0);
            FCLK_DIV8: smp_tick = rise & (cnt == 3'h0);
            default: smp_tick = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // per-monitor logic, index 0 is monitor 1, index 1 is monitor 2
    // ----------------------------------------------------------------
    mon_cfg_t cfg_r [2];
    mon_cfg_t cfg_nxt [2];
    mon_state_t st_r [2];
    mon_state_t st_nxt [2];
    logic [2:0] set_r [2];
    logic [2:0] set_nxt [2];
    logic [1:0] hist_r, hist_nxt, prev_r, prev_nxt, flag_r, flag_nxt, lvl_r, lvl_nxt;
    logic [1:0] en_in, we_in, clr_in, det_in, cmp_in, tick, qual, armed;
    mon_cfg_t wd [2];

    always_comb begin
        en_in = {MON2_EN, MON1_EN};
        we_in = {MON2_CFG_WE, MON1_CFG_WE};
        clr_in = {MON2_FLAG_CLR, MON1_FLAG_CLR};
        det_in = {det2_s, det1_s};
        cmp_in = {cmp2_s, cmp1_s};
        wd[0] = MON1_CFG_WDATA;
        wd[1] = MON2_CFG_WDATA;
        // monitor 1 has reset mode only in this version
        wd[0].mode_sel = MODE_RST;
        for (int i = 0; i < 2; i++) begin
            cfg_nxt[i] = cfg_r[i];
            // whole word lands at once, only while disabled
            if (we_in[i] && !en_in[i]) begin
                cfg_nxt[i] = wd[i];
            end
            tick[i] = smp_tick(cfg_r[i].filter_clk_sel, lso_rise, div_r);
            // filter: level accepted after two equal samples
            hist_nxt[i] = tick[i] ? cmp_in[i] : hist_r[i];
            lvl_nxt[i] = lvl_r[i];
            if (cfg_r[i].filter_off) begin
                lvl_nxt[i] = cmp_in[i];
            end else if (tick[i] && (hist_r[i] == cmp_in[i])) begin
                lvl_nxt[i] = cmp_in[i];
            end
            prev_nxt[i] = lvl_r[i];
            // timing 1 or filter on: falling to threshold; timing 0 with filter off: rising back above
            if (cfg_r[i].req_timing == TIMING_FALL || !cfg_r[i].filter_off) begin
                qual[i] = lvl_r[i] & ~prev_r[i];
            end else begin
                qual[i] = ~lvl_r[i] & prev_r[i];
            end
            st_nxt[i] = st_r[i];
            set_nxt[i] = set_r[i];
            case (st_r[i])
                ST_OFF: begin
                    set_nxt[i] = 3'h0;
                    if (en_in[i] && det_in[i]) begin
                        st_nxt[i] = cfg_r[i].filter_off ? ST_ARMED : ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tick[i]) begin
                        set_nxt[i] = set_r[i] + 3'h1;
                    end
                    if (set_r[i] == FILT_SETTLE_C) begin
                        st_nxt[i] = ST_ARMED;
                    end
                end
                ST_ARMED: ;
                default: st_nxt[i] = ST_OFF;
            endcase
            if (!en_in[i] || !det_in[i]) begin
                st_nxt[i] = ST_OFF;
            end
            armed[i] = (st_r[i] == ST_ARMED);
            // set wins over clear
            flag_nxt[i] = flag_r[i];
            if (clr_in[i]) begin
                flag_nxt[i] = 1'b0;
            end
            if (armed[i] && qual[i]) begin
                flag_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < 2; i++) begin
                cfg_r[i] <= '0;
                st_r[i] <= ST_OFF;
                set_r[i] <= 3'h0;
            end
            hist_r <= 2'h0;
            prev_r <= 2'h0;
            lvl_r <= 2'h0;
            flag_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                cfg_r[i] <= cfg_nxt[i];
                st_r[i] <= st_nxt[i];
                set_r[i] <= set_nxt[i];
            end
            hist_r <= hist_nxt;
            prev_r <= prev_nxt;
            lvl_r <= lvl_nxt;
            flag_r <= flag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // request outputs, registered
    // ----------------------------------------------------------------
    logic irq_r, irq_nxt, rst_r, rst_nxt;
    always_comb begin
        irq_nxt = armed[1] & qual[1] & (cfg_r[1].mode_sel == MODE_IRQ);
        // reset held until chip reset clears this block
        rst_nxt = rst_r | (armed[0] & qual[0] & (cfg_r[0].mode_sel == MODE_RST))
                | (armed[1] & qual[1] & (cfg_r[1].mode_sel == MODE_RST));
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_r <= 1'b0;
            rst_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            rst_r <= rst_nxt;
        end
    end

    assign MON1_CFG = cfg_r[0];
    assign MON2_CFG = cfg_r[1];
    assign MON1_PASS_FLAG = flag_r[0];
    assign MON2_PASS_FLAG = flag_r[1];
    assign MON1_ARMED = armed[0];
    assign MON2_ARMED = armed[1];
    assign MON2_IRQ = irq_r;
    assign CHIP_RST_REQ = rst_r;
endmodule

// ===== verification/vmon_ctrl_props.sv
// checker: port-level properties of the voltage monitor control block
`timescale 1ns/1ps
module vmon_ctrl_chk
    import vmon_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire vmon_pkg::mon_cfg_t MON1_CFG_WDATA,
    input wire logic MON1_CFG_WE,
    input wire logic MON1_EN,
    input wire logic MON2_EN,
    input wire logic [4:0] MON1_CFG,
    input wire logic [4:0] MON2_CFG,
    input wire logic MON1_ARMED,
    input wire logic MON2_ARMED,
    input wire logic MON2_IRQ,
    input wire logic CHIP_RST_REQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // ----
    // configuration and arming
    // ----
    property p_cfg1_lock; MON1_EN |=> $stable(MON1_CFG); endproperty
    a_cfg1_lock: assert property (p_cfg1_lock) else $error("mon1 cfg moved while enabled");
    property p_cfg2_lock; MON2_EN |=> $stable(MON2_CFG); endproperty
    a_cfg2_lock: assert property (p_cfg2_lock) else $error("mon2 cfg moved while enabled");
    property p_cfg1_wr; MON1_CFG_WE && !MON1_EN |=> MON1_CFG == ($past(MON1_CFG_WDATA) | 5'h08); endproperty
    a_cfg1_wr: assert property (p_cfg1_wr) else $error("mon1 cfg write wrong");
    property p_disarm; !MON1_EN |=> !MON1_ARMED; endproperty
    a_disarm: assert property (p_disarm) else $error("mon1 armed without enable");
    property p_arm; $rose(MON2_EN) && MON2_CFG[2] |-> ##[1:4] MON2_ARMED; endproperty
    a_arm: assert property (p_arm) else $error("mon2 did not arm");
    // a slow sample clock gives at least four ticks of settle
    property p_settle; $rose(MON2_EN) && !MON2_CFG[2] |=> !MON2_ARMED [*8]; endproperty
    a_settle: assert property (p_settle) else $error("mon2 armed before filter settle");
    // ----
    // requests
    // ----
    property p_irq; MON2_IRQ |-> MON2_CFG[3] == MODE_IRQ && !$past(MON2_IRQ); endproperty
    a_irq: assert property (p_irq) else $error("mon2 irq in wrong mode or too long");
    property p_rst; CHIP_RST_REQ |=> CHIP_RST_REQ; endproperty
    a_rst: assert property (p_rst) else $error("reset request dropped");
endmodule
bind vmon_ctrl vmon_ctrl_chk vmon_ctrl_chk_i (.CLK_SYS, .RSTN, .MON1_CFG_WDATA, .MON1_CFG_WE,
    .MON1_EN, .MON2_EN, .MON1_CFG, .MON2_CFG, .MON1_ARMED, .MON2_ARMED, .MON2_IRQ, .CHIP_RST_REQ);

// ===== verification/test_vmon_ctrl.sv
// testbench: directed scenarios for the voltage monitor control block
`timescale 1ns/1ps
module test_vmon_ctrl;
    import vmon_pkg::*;
    logic CLK_SYS = 1'b0, RSTN = 1'b0, LSO_CLK = 1'b0, LSO_STOP = 1'b0;
    logic DET1_CIRCUIT_EN = 1'b1, DET2_CIRCUIT_EN = 1'b1, CMP1_BELOW = 1'b0, CMP2_BELOW = 1'b0;
    logic MON1_CFG_WE = 1'b0, MON1_EN = 1'b0, MON1_FLAG_CLR = 1'b0;
    logic MON2_CFG_WE = 1'b0, MON2_EN = 1'b0, MON2_FLAG_CLR = 1'b0;
    mon_cfg_t MON1_CFG_WDATA = 5'h00, MON2_CFG_WDATA = 5'h00;
    logic [4:0] MON1_CFG, MON2_CFG;
    logic MON1_PASS_FLAG, MON2_PASS_FLAG, MON1_ARMED, MON2_ARMED, MON2_IRQ, CHIP_RST_REQ;
    int n_fail = 0, checks = 0;
    // ----
    // clocks and design
    // ----
    always #2.5 CLK_SYS = ~CLK_SYS;
    // slow oscillator: one filter tick every eight system cycles
    always #20 LSO_CLK = ~LSO_CLK;
    vmon_ctrl vmon_ctrl_i (.CLK_SYS, .RSTN, .LSO_CLK, .LSO_STOP, .DET1_CIRCUIT_EN, .DET2_CIRCUIT_EN,
        .CMP1_BELOW, .CMP2_BELOW, .MON1_CFG_WDATA, .MON1_CFG_WE, .MON1_EN, .MON1_FLAG_CLR,
        .MON2_CFG_WDATA, .MON2_CFG_WE, .MON2_EN, .MON2_FLAG_CLR, .MON1_CFG, .MON2_CFG,
        .MON1_PASS_FLAG, .MON2_PASS_FLAG, .MON1_ARMED, .MON2_ARMED, .MON2_IRQ, .CHIP_RST_REQ);
    // ----
    // shared tasks
    // ----
    task step(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task cmp(input string nm, input logic [4:0] exp, input logic [4:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait: 0 irq, 1 reset request, 2 mon2 armed
    task wait_for(input int sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((sel == 0 && MON2_IRQ) || (sel == 1 && CHIP_RST_REQ) || (sel == 2 && MON2_ARMED)) break;
            step(1);
        end
        if (i == lim) begin
            n_fail++;
            $display("mismatch wait %0d expected 1 seen 0", sel);
            conclude();
        end
    endtask
    task wr(input bit m2, input mon_cfg_t d);
        if (m2) begin
            MON2_CFG_WDATA = d;
            MON2_CFG_WE = 1'b1;
        end else begin
            MON1_CFG_WDATA = d;
            MON1_CFG_WE = 1'b1;
        end
        step(1);
        // lower only the strobe raised here, so back-to-back writes never drive one strobe twice
        if (m2) MON2_CFG_WE = 1'b0;
        else MON1_CFG_WE = 1'b0;
    endtask
    task clr1;
        MON1_FLAG_CLR = 1'b1;
        step(1);
        MON1_FLAG_CLR = 1'b0;
    endtask
    task clr2;
        MON2_FLAG_CLR = 1'b1;
        step(1);
        MON2_FLAG_CLR = 1'b0;
    endtask
    // ----
    // scenarios
    // ----
    task t_cfg;
        wr(0, 5'h07);
        cmp("mon1_cfg", 5'h0f, MON1_CFG);
        wr(1, 5'h1b);
        cmp("mon2_cfg", 5'h1b, MON2_CFG);
        MON1_EN = 1'b1;
        step(1);
        cmp("mon1_armed", 5'h01, {4'h0, MON1_ARMED});
        wr(0, 5'h14);
        cmp("mon1_cfg_locked", 5'h0f, MON1_CFG);
        // dropping the detection circuit disarms once the sync stages catch up
        DET1_CIRCUIT_EN = 1'b0;
        step(3);
        cmp("mon1_armed_nodet", 5'h00, {4'h0, MON1_ARMED});
        DET1_CIRCUIT_EN = 1'b1;
        MON1_EN = 1'b0;
        step(1);
    endtask
    // detection ignored while disabled, then unfiltered interrupt with the oscillator stopped
    task t_irq;
        LSO_STOP = 1'b1;
        wr(1, 5'h14);
        CMP2_BELOW = 1'b1;
        step(6);
        cmp("mon2_flag_idle", 5'h00, {4'h0, MON2_PASS_FLAG});
        CMP2_BELOW = 1'b0;
        clr2();
        MON2_EN = 1'b1;
        wait_for(2, 4);
        CMP2_BELOW = 1'b1;
        wait_for(0, 8);
        cmp("mon2_flag", 5'h01, {4'h0, MON2_PASS_FLAG});
        step(1);
        cmp("mon2_irq_pulse", 5'h00, {4'h0, MON2_IRQ});
        cmp("rst_req", 5'h00, {4'h0, CHIP_RST_REQ});
        CMP2_BELOW = 1'b0;
        MON2_EN = 1'b0;
        clr2();
        cmp("mon2_flag_clr", 5'h00, {4'h0, MON2_PASS_FLAG});
    endtask
    // timing 0: no request on the fall, one when the supply climbs back above
    task t_rise;
        wr(1, 5'h04);
        CMP2_BELOW = 1'b1;
        step(4);
        clr2();
        MON2_EN = 1'b1;
        wait_for(2, 4);
        step(4);
        cmp("mon2_flag_fall", 5'h00, {4'h0, MON2_PASS_FLAG});
        CMP2_BELOW = 1'b0;
        wait_for(0, 8);
        cmp("mon2_flag_rise", 5'h01, {4'h0, MON2_PASS_FLAG});
        MON2_EN = 1'b0;
        clr2();
    endtask
    // filtered interrupt: oscillator on before the enable, arming only after the settle ticks
    task t_filt;
        LSO_STOP = 1'b0;
        wr(1, 5'h00);
        MON2_EN = 1'b1;
        step(8);
        cmp("mon2_armed_early", 5'h00, {4'h0, MON2_ARMED});
        wait_for(2, 200);
        CMP2_BELOW = 1'b1;
        wait_for(0, 200);
        cmp("mon2_flag_filt", 5'h01, {4'h0, MON2_PASS_FLAG});
        MON2_EN = 1'b0;
        CMP2_BELOW = 1'b0;
        clr2();
    endtask
    task rst_seq;
        RSTN = 1'b0;
        MON1_EN = 1'b0;
        MON2_EN = 1'b0;
        CMP1_BELOW = 1'b0;
        CMP2_BELOW = 1'b0;
        step(4);
        RSTN = 1'b1;
    endtask
    // unfiltered reset mode on either monitor, usable for stop-mode wake; the request holds until reset
    task t_rst(input bit m2);
        wr(m2, 5'h1c);
        if (m2) clr2();
        else clr1();
        MON1_EN = !m2;
        MON2_EN = m2;
        step(2);
        if (m2) CMP2_BELOW = 1'b1;
        else CMP1_BELOW = 1'b1;
        wait_for(1, 8);
        cmp("pass_flag", 5'h01, {4'h0, (m2 ? MON2_PASS_FLAG : MON1_PASS_FLAG)});
        cmp("mon2_irq_rst", 5'h00, {4'h0, MON2_IRQ});
        if (m2) clr2();
        else clr1();
        cmp("pass_flag_clr", 5'h00, {4'h0, (m2 ? MON2_PASS_FLAG : MON1_PASS_FLAG)});
        cmp("rst_req_held", 5'h01, {4'h0, CHIP_RST_REQ});
        rst_seq();
        step(1);
        cmp("rst_req_clr", 5'h00, {4'h0, CHIP_RST_REQ});
    endtask
    initial begin
        rst_seq();
        t_cfg();
        t_irq();
        t_rise();
        t_filt();
        t_rst(1);
        t_rst(0);
        conclude();
    end
endmodule
